/* bench/iorf_cpu_model.sv */
// Behavioural model of the CPU I/O control module on the parallel chain
`timescale 1ns/1ns
`default_nettype none
module iorf_cpu_model (
	clk,
	chain_out_strobe,
	chain_out_addr,
	chain_out_data,
	parity_err,
	parity_err_addr_phase,
	cpu_running
);
	input wire logic clk;
	output var logic chain_out_strobe;
	output var logic [7:0] chain_out_addr;
	output var logic [7:0] chain_out_data;
	output var logic parity_err;
	output var logic parity_err_addr_phase;
	output var logic cpu_running;

	// Idle chain: released lines carry a pattern that never matches byte 0
	initial begin
		chain_out_strobe = 1'b0;
		chain_out_addr = 8'hA5;
		chain_out_data = 8'h5A;
		parity_err = 1'b0;
		parity_err_addr_phase = 1'b0;
		cpu_running = 1'b0;
	end

	// Byte write; lines stand 3 cycles past the strobe, then show the
	// inverse so a stale value is never mistaken for a held one
	task automatic send_byte(input logic [7:0] a, input logic [7:0] d);
		chain_out_addr <= a;
		chain_out_data <= d;
		chain_out_strobe <= 1'b1;
		repeat (4) @(posedge clk);
		chain_out_strobe <= 1'b0;
		repeat (3) @(posedge clk);
		chain_out_addr <= ~a;
		chain_out_data <= ~d;
		repeat (2) @(posedge clk);
	endtask : send_byte

	// One output parity error, phase given alongside the error level
	task automatic parity_hit(input logic addr_phase);
		parity_err_addr_phase <= addr_phase;
		parity_err <= 1'b1;
		repeat (3) @(posedge clk);
		parity_err <= 1'b0;
		repeat (2) @(posedge clk);
	endtask : parity_hit

	task automatic set_run(input logic r);
		cpu_running <= r;
		@(posedge clk);
	endtask : set_run
endmodule : iorf_cpu_model
`default_nettype wire

/* bench/tb.sv */
// Self-checking bench for the rack fault-status latch
`timescale 1ns/1ns
`default_nettype none
module tb
	import iorf_pkg::*;
;
	logic clk, resetn, hsel, hwrite, hready, hreadyout, hresp;
	// Indicator pins in the same bit order as the status word
	wire logic [8:0] ind;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic strobe, perr, pphase, run, xfault, dfault, button_n;
	logic [7:0] caddr, cdata, sw;
	int bad_count, comparisons;

	assign hready = hreadyout;

	iorf_fault_latch u_iorf_fault_latch (.clk(clk), .resetn(resetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.chain_out_strobe(strobe), .chain_out_addr(caddr),
		.chain_out_data(cdata), .addr_switch(sw), .parity_err(perr),
		.parity_err_addr_phase(pphase), .cpu_running(run),
		.xmit_link_fault(xfault), .downstream_fault(dfault),
		.reset_button_n(button_n), .status_lamp_on(ind[8]),
		.local_parity_good(ind[0]), .address_phase_parity_good(ind[1]),
		.data_phase_parity_good(ind[2]), .output_parity_latch(ind[3]),
		.transmit_link_good(ind[4]), .chain_good(ind[5]),
		.downstream_chain_good(ind[6]), .fault_upstream(ind[7]));

	iorf_cpu_model u_iorf_cpu_model (.clk(clk), .chain_out_strobe(strobe),
		.chain_out_addr(caddr), .chain_out_data(cdata), .parity_err(perr),
		.parity_err_addr_phase(pphase), .cpu_running(run));

	// ************************************************************
	// Bus and check tasks
	// ************************************************************
	// Single word transfer; waits on hready at both phases, never a count
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= IORF_HTRANS_NONSEQ;
		haddr <= {24'h000000, a};
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : xfer

	task automatic chk(input string nm, input logic [31:0] exp,
		input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("FAIL %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic rchk(input string nm, input logic [7:0] a,
		input logic [31:0] exp);
		xfer(1'b0, a, 32'h00000000);
		chk(nm, exp, rd);
		chk("hresp", 32'h00000000, {31'h0, hresp});
		// Settled indicator pins must agree with the status word
		if (a == IORF_ADDR_STATUS) begin
			chk({nm, " pins"}, exp, {23'h000000, ind});
		end
	endtask : rchk

	// Pins pass two flops plus a register, so six cycles is ample
	task automatic settle;
		repeat (6) @(posedge clk);
	endtask : settle

	task automatic press;
		button_n <= 1'b0;
		settle;
		button_n <= 1'b1;
		settle;
	endtask : press

	task automatic give_verdict;
		$display("Counts: %0d compared, %0d mismatched", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : give_verdict

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Watchdog: the whole sequence needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clk);
		bad_count++;
		give_verdict;
	end

	// ************************************************************
	// Test sequence
	// ************************************************************
	initial begin
		resetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h00000000;
		xfault = 1'b0;
		dfault = 1'b0;
		button_n = 1'b1;
		sw = 8'h00;
		bad_count = 0;
		comparisons = 0;
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		repeat (8) @(posedge clk);
		rchk("status", IORF_ADDR_STATUS, 32'h0000017F);
		rchk("ctrl", IORF_ADDR_CTRL, 32'h00000001);
		rchk("unmapped", 8'h10, 32'h00000000);
		$display("test reset done");
		// Only the switch-selected byte reaches the lamp
		u_iorf_cpu_model.send_byte(8'h03, 8'h04);
		settle;
		rchk("foreign byte", IORF_ADDR_STATUS, 32'h0000017F);
		u_iorf_cpu_model.send_byte(8'h00, 8'h04);
		settle;
		rchk("lamp off", IORF_ADDR_STATUS, 32'h0000007F);
		rchk("out byte", IORF_ADDR_OUTBYTE, 32'h00000004);
		sw <= 8'h3C;
		settle;
		u_iorf_cpu_model.send_byte(8'h3C, 8'h00);
		settle;
		rchk("lamp on", IORF_ADDR_STATUS, 32'h0000017F);
		rchk("switch", IORF_ADDR_SWITCH, 32'h0000003C);
		sw <= 8'h00;
		settle;
		$display("test output byte done");
		// Parity phases, automatic recovery and the sticky latch
		u_iorf_cpu_model.parity_hit(1'b1);
		settle;
		rchk("addr phase", IORF_ADDR_STATUS, 32'h000001D4);
		u_iorf_cpu_model.set_run(1'b1);
		settle;
		rchk("retry", IORF_ADDR_STATUS, 32'h00000177);
		u_iorf_cpu_model.set_run(1'b0);
		u_iorf_cpu_model.parity_hit(1'b0);
		settle;
		rchk("data phase", IORF_ADDR_STATUS, 32'h000001D2);
		u_iorf_cpu_model.set_run(1'b1);
		settle;
		rchk("restart", IORF_ADDR_STATUS, 32'h00000177);
		press;
		rchk("button clear", IORF_ADDR_STATUS, 32'h0000017F);
		$display("test parity done");
		// Transmit link fault, present then latched, cleared by bit 2
		xfault <= 1'b1;
		settle;
		rchk("xmit now", IORF_ADDR_STATUS, 32'h000001CF);
		chk("upstream pin", 32'h00000001, {31'h0, ind[7]});
		xfault <= 1'b0;
		settle;
		rchk("xmit latched", IORF_ADDR_STATUS, 32'h0000016F);
		u_iorf_cpu_model.send_byte(8'h00, 8'h02);
		u_iorf_cpu_model.send_byte(8'h00, 8'h00);
		settle;
		rchk("bit2 clear", IORF_ADDR_STATUS, 32'h0000017F);
		$display("test transmit link done");
		// Downstream fault; a clear while present must not restore it
		dfault <= 1'b1;
		settle;
		rchk("down now", IORF_ADDR_STATUS, 32'h0000019F);
		press;
		rchk("clear held", IORF_ADDR_STATUS, 32'h0000019F);
		dfault <= 1'b0;
		settle;
		// Fault gone: only the latch stays off, nothing is reported up
		rchk("down latched", IORF_ADDR_STATUS, 32'h0000013F);
		xfer(1'b1, IORF_ADDR_CTRL, 32'h00000003);
		settle;
		rchk("soft clear", IORF_ADDR_STATUS, 32'h0000017F);
		$display("test downstream done");
		// Reporting switched off: fault shown locally, not sent up
		xfer(1'b1, IORF_ADDR_CTRL, 32'h00000000);
		rchk("ctrl off", IORF_ADDR_CTRL, 32'h00000000);
		xfault <= 1'b1;
		settle;
		rchk("no report", IORF_ADDR_STATUS, 32'h0000014F);
		xfault <= 1'b0;
		settle;
		xfer(1'b1, IORF_ADDR_CTRL, 32'h00000003);
		settle;
		rchk("restored", IORF_ADDR_STATUS, 32'h0000017F);
		$display("test reporting done");
		give_verdict;
	end
endmodule : tb
`default_nettype wire

/* logic/iorf_fault_latch.sv */
// Fault-status latching and indicator logic of a remote rack receiver
//
// Function
// R1: Program lamp follows output byte bit 3 directly; program decides its state. The code lights the lamp while bit 3 is off.
// R2: Output byte base comes from address switches; all closed gives point 00001.
// R3: Any output parity error latches the output-parity indicator until reset.
// R4: Address-phase error clears local, address-phase and output parity good.
// R5: Data-phase error clears local, data-phase and output parity good.
// R6: Phase parity indicators return good automatically while the CPU runs.
// R7: After retry or restart, local and phase good; output latch stays faulted.
// R8: Pushbutton, or output byte bit 2 on then off, clears all latches.
// R9: Any transmit link power or continuity loss latches transmit-good off.
// R10: Present transmit link fault holds chain and transmit good off, reports up.
// R11: Any downstream rack loss latches downstream-chain-good off until reset.
// R12: Present downstream fault holds both chain goods off and reports upstream.
// R13: Reset restores an indicator only when its fault is no longer present.
`timescale 1ns/1ns
`default_nettype none
module iorf_fault_latch
	import iorf_pkg::*;
#(
	parameter int SWITCH_W = IORF_SWITCH_W
) (
	clk,
	resetn,
	hsel,
	haddr,
	htrans,
	hwrite,
	hsize,
	hwdata,
	hready,
	hreadyout,
	hresp,
	hrdata,
	chain_out_strobe,
	chain_out_addr,
	chain_out_data,
	addr_switch,
	parity_err,
	parity_err_addr_phase,
	cpu_running,
	xmit_link_fault,
	downstream_fault,
	reset_button_n,
	status_lamp_on,
	local_parity_good,
	address_phase_parity_good,
	data_phase_parity_good,
	output_parity_latch,
	transmit_link_good,
	chain_good,
	downstream_chain_good,
	fault_upstream
);
	input wire logic clk;
	input wire logic resetn;
	input wire logic hsel;
	input wire logic [31:0] haddr;
	input wire logic [1:0] htrans;
	input wire logic hwrite;
	input wire logic [2:0] hsize;
	input wire logic [31:0] hwdata;
	input wire logic hready;
	output logic hreadyout;
	output logic hresp;
	output logic [31:0] hrdata;
	input wire logic chain_out_strobe;
	input wire logic [SWITCH_W-1:0] chain_out_addr;
	input wire logic [IORF_BYTE_W-1:0] chain_out_data;
	input wire logic [SWITCH_W-1:0] addr_switch;
	input wire logic parity_err;
	input wire logic parity_err_addr_phase;
	input wire logic cpu_running;
	input wire logic xmit_link_fault;
	input wire logic downstream_fault;
	input wire logic reset_button_n;
	output logic status_lamp_on;
	output logic local_parity_good;
	output logic address_phase_parity_good;
	output logic data_phase_parity_good;
	output logic output_parity_latch;
	output logic transmit_link_good;
	output logic chain_good;
	output logic downstream_chain_good;
	output logic fault_upstream;

	localparam int SYNC_W = 2 * SWITCH_W + IORF_BYTE_W + 7;

	// ************************************************************
	// State record
	// ************************************************************
	typedef struct packed {
		logic dp_act;
		logic dp_wr;
		logic [7:0] dp_addr;
		logic [31:0] rdata;
		logic report_en;
		logic sw_clear;
		logic [IORF_BYTE_W-1:0] out_byte;
		logic strobe_prev;
		logic clr_bit_prev;
		logic err_prev;
		logic loc_bad;
		logic addr_bad;
		logic data_bad;
		logic out_bad;
		logic xmit_lost;
		logic down_lost;
		logic lamp;
		logic chain_ok;
		logic upstream;
	} iorf_state_type;

	localparam iorf_state_type STATE_RESET = '{
		dp_act: 1'b0, dp_wr: 1'b0, dp_addr: 8'h00, rdata: 32'h00000000,
		report_en: IORF_REPORT_RESET, sw_clear: 1'b0,
		out_byte: IORF_OUT_BYTE_RESET, strobe_prev: 1'b0,
		clr_bit_prev: 1'b0, err_prev: 1'b0, loc_bad: 1'b0,
		addr_bad: 1'b0, data_bad: 1'b0, out_bad: 1'b0,
		xmit_lost: 1'b0, down_lost: 1'b0, lamp: 1'b1,
		chain_ok: 1'b1, upstream: 1'b0
	};

	iorf_state_type s_q;
	iorf_state_type s_d;

	// ************************************************************
	// Reset release and pin synchronisation
	// ************************************************************
	logic rst_n_s;
	logic [SYNC_W-1:0] pins_s;
	logic strobe_s;
	logic [SWITCH_W-1:0] caddr_s;
	logic [IORF_BYTE_W-1:0] cdata_s;
	logic [SWITCH_W-1:0] switch_s;
	logic err_s;
	logic err_aph_s;
	logic run_s;
	logic xmit_now;
	logic down_now;
	logic button_s;

	// Reset is asserted at once but released through two flops
	iorf_sync #(
		.WIDTH(1)
	) u_rst_sync (
		.clk(clk),
		.rst_n(resetn),
		.d(1'b1),
		.q(rst_n_s)
	);

	// Every pin is outside this clock, so all pass two flops
	iorf_sync #(
		.WIDTH(SYNC_W)
	) u_pin_sync (
		.clk(clk),
		.rst_n(rst_n_s),
		.d({chain_out_strobe, chain_out_addr, chain_out_data,
			addr_switch, parity_err, parity_err_addr_phase,
			cpu_running, xmit_link_fault, downstream_fault,
			~reset_button_n}),
		.q(pins_s)
	);

	assign {strobe_s, caddr_s, cdata_s, switch_s, err_s, err_aph_s, run_s,
		xmit_now, down_now, button_s} = pins_s;

	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic logic [31:0] read_mux(
		input logic [7:0] addr,
		input iorf_state_type s,
		input logic [SWITCH_W-1:0] sw
	);
		logic [31:0] r;
		r = 32'h00000000;
		case (addr)
			IORF_ADDR_CTRL: begin
				r[IORF_CTRL_REPORT_BIT] = s.report_en;
			end
			IORF_ADDR_STATUS: begin
				r[IORF_ST_WIDTH-1:0] = status_word(s);
			end
			IORF_ADDR_OUTBYTE: begin
				r[IORF_BYTE_W-1:0] = s.out_byte;
			end
			IORF_ADDR_SWITCH: begin
				r[SWITCH_W-1:0] = sw;
			end
			default: begin
				r = 32'h00000000;
			end
		endcase
		return r;
	endfunction : read_mux

	function automatic logic [IORF_ST_WIDTH-1:0] status_word(
		input iorf_state_type s
	);
		logic [IORF_ST_WIDTH-1:0] w;
		w = '0;
		w[IORF_ST_LOCAL_PAR] = ~s.loc_bad;
		w[IORF_ST_ADDR_PAR] = ~s.addr_bad;
		w[IORF_ST_DATA_PAR] = ~s.data_bad;
		w[IORF_ST_OUT_PAR] = ~s.out_bad;
		w[IORF_ST_XMIT] = ~s.xmit_lost;
		w[IORF_ST_CHAIN] = s.chain_ok;
		w[IORF_ST_DOWN] = ~s.down_lost;
		w[IORF_ST_UPSTREAM] = s.upstream;
		w[IORF_ST_LAMP] = s.lamp;
		return w;
	endfunction : status_word

	// ************************************************************
	// Next-state logic
	// ************************************************************
	logic take;
	logic strobe_rise;
	logic err_evt;
	logic clear;
	logic clr_bit_fall;

	// Bus request, output byte strobe and fault events
	always_comb begin
		take = hsel & hready & (htrans == IORF_HTRANS_NONSEQ);
		strobe_rise = strobe_s & ~s_q.strobe_prev;
		err_evt = err_s & ~s_q.err_prev;
		clr_bit_fall = s_q.clr_bit_prev & ~s_q.out_byte[IORF_OUT_CLEAR_IDX];
		clear = button_s | clr_bit_fall | s_q.sw_clear; // see R8
	end

	// One copy of the state, filled every cycle
	always_comb begin
		s_d = s_q;
		s_d.dp_act = take;
		s_d.dp_wr = take & hwrite;
		s_d.sw_clear = 1'b0;
		if (take) begin
			s_d.dp_addr = haddr[7:0];
		end
		// Read data is latched with the address so it stands in the data phase
		if (take && !hwrite) begin
			s_d.rdata = read_mux(haddr[7:0], s_q, switch_s);
		end
		if (s_q.dp_wr && s_q.dp_addr == IORF_ADDR_CTRL) begin
			s_d.report_en = hwdata[IORF_CTRL_REPORT_BIT];
			s_d.sw_clear = hwdata[IORF_CTRL_CLEAR_BIT];
		end

		// Output byte taken only at this rack's switch address
		s_d.strobe_prev = strobe_s;
		if (strobe_rise && caddr_s == switch_s) begin // see R2
			s_d.out_byte = cdata_s;
		end
		s_d.clr_bit_prev = s_q.out_byte[IORF_OUT_CLEAR_IDX];
		s_d.lamp = ~s_q.out_byte[IORF_OUT_LAMP_IDX]; // see R1

		// Parity latches: a new error wins over any clear in the same cycle
		s_d.err_prev = err_s;
		s_d.out_bad = err_evt | (s_q.out_bad & ~clear); // see R3, R7
		s_d.loc_bad = err_evt | (s_q.loc_bad & ~clear & ~run_s); // see R7
		s_d.addr_bad = (err_evt & err_aph_s) // see R4
			| (s_q.addr_bad & ~clear & ~run_s); // see R6
		s_d.data_bad = (err_evt & ~err_aph_s) // see R5
			| (s_q.data_bad & ~clear & ~run_s); // see R6

		// Link latches stay faulted while the fault is still present
		s_d.xmit_lost = xmit_now | (s_q.xmit_lost & ~clear); // see R9, R13
		s_d.down_lost = down_now | (s_q.down_lost & ~clear); // see R11, R13

		// Present faults drop the rack chain indicator and go upstream
		s_d.chain_ok = ~(xmit_now | down_now | s_d.loc_bad); // see R10, R12
		s_d.upstream = s_q.report_en
			& (xmit_now | down_now | s_d.loc_bad); // see R10, R12
	end

	// ************************************************************
	// State register
	// ************************************************************
	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			s_q <= STATE_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs come straight from state flops, but hreadyout is always high and hresp always low; slave is never stalled
	assign hreadyout = 1'b1 | s_q.dp_act;
	assign hresp = 1'b0 & s_q.dp_act;
	assign hrdata = s_q.rdata;
	assign status_lamp_on = s_q.lamp;
	assign local_parity_good = ~s_q.loc_bad;
	assign address_phase_parity_good = ~s_q.addr_bad;
	assign data_phase_parity_good = ~s_q.data_bad;
	assign output_parity_latch = ~s_q.out_bad;
	assign transmit_link_good = ~s_q.xmit_lost;
	assign chain_good = s_q.chain_ok;
	assign downstream_chain_good = ~s_q.down_lost;
	assign fault_upstream = s_q.upstream;

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n_s);

	a_lamp_follows_bit: assert property ( // see R1
		s_q.out_byte[IORF_OUT_LAMP_IDX] |-> ##1 !status_lamp_on)
		else $error("lamp lit while output bit 3 set");

	a_byte_addr_match: assert property ( // see R2
		(strobe_rise && caddr_s != switch_s) |=> $stable(s_q.out_byte))
		else $error("output byte taken at foreign address");

	a_out_parity_latch: assert property ( // see R3
		err_evt |=> !output_parity_latch)
		else $error("output parity latch not set by error");

	a_addr_phase_err: assert property ( // see R4
		(err_evt && err_aph_s && !s_q.data_bad) |=> (!local_parity_good
		&& !address_phase_parity_good && data_phase_parity_good))
		else $error("address phase error pattern wrong");

	a_data_phase_err: assert property ( // see R5
		(err_evt && !err_aph_s && !s_q.addr_bad) |=> (!local_parity_good
		&& !data_phase_parity_good && address_phase_parity_good))
		else $error("data phase error pattern wrong");

	a_phase_run_clear: assert property ( // see R6
		(run_s && !err_evt) |=> (address_phase_parity_good
		&& data_phase_parity_good))
		else $error("phase indicators not cleared while running");

	a_out_parity_holds: assert property ( // see R7
		(s_q.out_bad && !clear) |=> !output_parity_latch)
		else $error("output parity latch dropped without reset");

	a_button_clear: assert property ( // see R8
		(button_s && !err_evt && !xmit_now && !down_now) |=>
		(output_parity_latch && transmit_link_good && downstream_chain_good))
		else $error("pushbutton did not clear latches");

	a_xmit_latch: assert property ( // see R9
		(xmit_now ##1 !xmit_now && !clear) |=> !transmit_link_good)
		else $error("brief transmit loss not latched");

	a_xmit_present: assert property ( // see R10
		xmit_now |=> (!chain_good && !transmit_link_good
		&& (fault_upstream == $past(s_q.report_en))))
		else $error("present transmit fault not shown");

	a_down_present: assert property ( // see R11, R12
		down_now |=> (!chain_good && !downstream_chain_good))
		else $error("present downstream fault not shown");

	a_reset_persist: assert property ( // see R13
		(clear && down_now) |=> !downstream_chain_good)
		else $error("reset cleared a persisting fault");

	c_addr_phase: cover property (err_evt && err_aph_s);
	c_bit2_clear: cover property (clr_bit_fall && s_q.out_bad);
	c_xmit_brief: cover property (xmit_now ##1 !xmit_now [*2]);
	c_bus_read: cover property (take && !hwrite ##1 s_q.dp_act);
endmodule : iorf_fault_latch
`default_nettype wire

/* logic/iorf_pkg.sv */
// Constants shared by the rack fault-status latch design
package iorf_pkg;

	// ************************************************************
	// Bus register map (byte addresses, one word each)
	// ************************************************************
	localparam logic [7:0] IORF_ADDR_CTRL = 8'h00;
	localparam logic [7:0] IORF_ADDR_STATUS = 8'h04;
	localparam logic [7:0] IORF_ADDR_OUTBYTE = 8'h08;
	localparam logic [7:0] IORF_ADDR_SWITCH = 8'h0C;

	// Control register fields and reset value
	localparam int IORF_CTRL_REPORT_BIT = 0;
	localparam int IORF_CTRL_CLEAR_BIT = 1;
	localparam logic IORF_REPORT_RESET = 1'b1;

	// ************************************************************
	// Status register field positions (1 = good / present)
	// ************************************************************
	localparam int IORF_ST_LOCAL_PAR = 0;
	localparam int IORF_ST_ADDR_PAR = 1;
	localparam int IORF_ST_DATA_PAR = 2;
	localparam int IORF_ST_OUT_PAR = 3;
	localparam int IORF_ST_XMIT = 4;
	localparam int IORF_ST_CHAIN = 5;
	localparam int IORF_ST_DOWN = 6;
	localparam int IORF_ST_UPSTREAM = 7;
	localparam int IORF_ST_LAMP = 8;
	localparam int IORF_ST_WIDTH = 9;

	// ************************************************************
	// Output byte layout and widths
	// ************************************************************
	localparam int IORF_BYTE_W = 8;
	localparam int IORF_SWITCH_W = 8;
	// Bits are numbered from 1, so bit n sits at index n-1
	localparam int IORF_OUT_CLEAR_IDX = 1;
	localparam int IORF_OUT_LAMP_IDX = 2;
	localparam logic [7:0] IORF_OUT_BYTE_RESET = 8'h00;

	// AHB-Lite transfer type carrying a request
	localparam logic [1:0] IORF_HTRANS_NONSEQ = 2'h2;

endpackage : iorf_pkg

/* logic/iorf_sync.sv */
// Two-stage synchroniser for a bundle of asynchronous levels
`timescale 1ns/1ns
`default_nettype none
module iorf_sync #(
	parameter int WIDTH = 1
) (
	clk,
	rst_n,
	d,
	q
);
	input wire logic clk;
	input wire logic rst_n;
	input wire logic [WIDTH-1:0] d;
	output logic [WIDTH-1:0] q;

	logic [WIDTH-1:0] meta_q;

	// First stage feeds only the second stage
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '0;
			q <= '0;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule : iorf_sync
`default_nettype wire
